// ===== rtl/flash_self_program_control.sv
// sequencer for flash self-programming: control register, store/load decode, halting
//
// Overview of operation
// - irq asserted while enabled and store idle
// - irq suppressed during eeprom write or store
// - busy flag set while region blocked
// - busy flag zero without read-while-write support
// - signature read load within three cycles
// - store after signature select does nothing
// - re-enable during fill clears page buffer
// - lock/fuse load chosen by the two low pointer bits
// - page write store writes buffer page
// - page write select clears done or timeout
// - core halted during store-started write/erase of a halting-region page
// - page erase store erases addressed page
// - store alone writes operand pair to buffer
// - store enable clears; held during erase/write
// - only five listed patterns arm actions
// - stores from application region are disabled
// - loader region stores reach any page
// - rww programming keeps core running, halting-region fetch
// - halting-region programming halts core, nothing readable
// - loader region lies inside halting region
// - page address latched at operation start
// - lock/fuse select clears after read/timeout
// - pointer values select lock or fuse bytes
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
module flash_self_program_control #(
	parameter bit                                  HAS_RWW        = 1'b1,
	parameter logic [flash_spc_pkg::PAGE_W-1:0]    RWW_PAGES      = 9'h1c0,
	parameter logic [flash_spc_pkg::ADDR_W-1:0]    LOADER_START_W = 15'h7000
) (
	// clock and reset
	input  wire logic                              i_core_clk,
	input  wire logic                              i_rst_n,
	// register port
	input  wire logic [3:0]                        i_reg_addr,
	input  wire logic [7:0]                        i_reg_wdata,
	input  wire logic                              i_reg_wr,
	input  wire logic                              i_reg_rd,
	output logic [7:0]                             o_reg_rdata,
	// core instruction side
	input  wire logic                              i_store_instr,
	input  wire logic                              i_load_instr,
	input  wire logic [15:0]                       i_pointer,
	input  wire logic [15:0]                       i_operand_pair,
	input  wire logic [flash_spc_pkg::ADDR_W-1:0]  i_fetch_addr,
	input  wire logic                              i_global_irq_en,
	input  wire logic                              i_eeprom_busy,
	output logic [7:0]                             o_load_data,
	output logic                                   o_load_override,
	output logic                                   o_core_halt,
	output logic                                   o_rww_read_blocked,
	output logic                                   o_flash_read_blocked,
	output logic                                   o_store_ready_irq,
	// lock, fuse and signature sources
	input  wire logic [7:0]                        i_lock_bits,
	input  wire logic [7:0]                        i_fuse_low,
	input  wire logic [7:0]                        i_fuse_high,
	input  wire logic [7:0]                        i_fuse_ext,
	input  wire logic [7:0]                        i_signature_byte,
	// flash array side
	input  wire logic                              i_array_done,
	output logic                                   o_array_start,
	output logic                                   o_array_write,
	output logic [flash_spc_pkg::PAGE_W-1:0]       o_array_page,
	output logic [15:0]                            o_buf_word,
	output logic [flash_spc_pkg::PAGE_WORD_W-1:0]  o_buf_index
);
	import flash_spc_pkg::*;

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic                    irq_en_q;
	logic [4:0]              action_q;
	logic                    sig_q;
	logic [2:0]              window_q;
	logic                    rww_busy_q;
	logic                    op_rww_q;
	logic                    buf_filling_q;
	logic [15:0]             buf_mem [BUF_WORDS];
	logic [BUF_WORDS-1:0]    buf_valid_q;
	logic [7:0]              rdata_q;
	logic [7:0]              load_data_q;
	logic                    load_ovr_q;
	op_type                  op_q;
	logic                    halt_q;
	flash_op_if              op_if ();

	function automatic logic in_loader(input logic [ADDR_W-1:0] a);
		in_loader = a >= LOADER_START_W;
	endfunction

	function automatic logic in_rww(input logic [PAGE_W-1:0] p);
		in_rww = HAS_RWW && (p < RWW_PAGES);
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic              ctl_wr;
	logic              pattern_ok;
	logic              arm_wr;
	logic              armed;
	logic              from_loader;
	logic              store_hit;
	logic              load_hit;
	logic [PAGE_W-1:0] ptr_page;

	assign ctl_wr     = i_reg_wr && (i_reg_addr == ADDR_CONTROL);
	assign pattern_ok = (i_reg_wdata[4:0] == PAT_REENABLE) || (i_reg_wdata[4:0] == PAT_LOCKFUSE) ||
		(i_reg_wdata[4:0] == PAT_PGWRITE) || (i_reg_wdata[4:0] == PAT_PGERASE) ||
		(i_reg_wdata[4:0] == PAT_STORE);
	assign arm_wr      = ctl_wr && pattern_ok && !action_q[BIT_STORE_EN] && (op_q == OP_IDLE) && !op_if.done;
	assign armed       = action_q[BIT_STORE_EN] && (window_q != 3'h0) && (op_q == OP_IDLE);
	assign from_loader = in_loader(i_fetch_addr);
	assign store_hit   = i_store_instr && armed && from_loader;
	assign load_hit    = i_load_instr && armed && (window_q > (STORE_WINDOW - LOAD_WINDOW));
	assign ptr_page    = i_pointer[15:PAGE_WORD_W+1];

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_en_q <= CONTROL_RESET[BIT_IRQ_EN];
		end else if (ctl_wr) begin
			irq_en_q <= i_reg_wdata[BIT_IRQ_EN];
		end
	end

	// a new arm is refused while an erase or write still runs
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			action_q <= CONTROL_RESET[4:0];
			window_q <= 3'h0;
		end else if (op_if.done) begin
			action_q <= 5'h00;
			window_q <= 3'h0;
		end else if (op_q != OP_IDLE) begin
			action_q <= action_q;
		end else if (ctl_wr && pattern_ok && !action_q[BIT_STORE_EN]) begin
			action_q <= i_reg_wdata[4:0];
			window_q <= STORE_WINDOW;
		end else if (store_hit && (action_q == PAT_PGWRITE || action_q == PAT_PGERASE)) begin
			window_q <= 3'h0;
		end else if (store_hit || (load_hit && (action_q == PAT_LOCKFUSE || sig_q))) begin
			action_q <= 5'h00;
			window_q <= 3'h0;
		end else if (window_q == 3'h1 || (window_q == 3'h0 && action_q != 5'h00)) begin
			action_q <= 5'h00;
			window_q <= 3'h0;
		end else if (window_q != 3'h0) begin
			window_q <= window_q - 3'h1;
		end
	end

	// only meaningful while the store bit is armed; a new arm always rewrites it
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sig_q <= 1'b0;
		end else if (arm_wr) begin
			sig_q <= (i_reg_wdata[5:0] == PAT_SIG);
		end else if (action_q == 5'h00) begin
			sig_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// page operations
	// ------------------------------------------------------------
	logic start_op;
	assign start_op = store_hit && (action_q == PAT_PGWRITE || action_q == PAT_PGERASE);

	assign op_if.start      = start_op;
	assign op_if.is_write   = (action_q == PAT_PGWRITE);
	assign op_if.page       = ptr_page;
	assign op_if.rww_target = in_rww(ptr_page);

	flash_op_tracker u_tracker (
		.i_core_clk   (i_core_clk),
		.i_rst_n      (i_rst_n),
		.i_array_done (i_array_done),
		.op           (op_if)
	);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			op_q     <= OP_IDLE;
			op_rww_q <= 1'b0;
		end else begin
			case (op_q)
				OP_IDLE: begin
					if (start_op) begin
						op_q     <= (action_q == PAT_PGWRITE) ? OP_WRITE : OP_ERASE;
						op_rww_q <= in_rww(ptr_page);
					end
				end
				OP_ERASE, OP_WRITE: begin
					if (op_if.done) begin
						op_q <= OP_IDLE;
					end
				end
				default: op_q <= OP_IDLE;
			endcase
		end
	end

	// halt only for halting-region targets; rww targets keep the core running
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			halt_q <= 1'b0;
		end else if (start_op) begin
			halt_q <= !in_rww(ptr_page);
		end else if (op_if.done) begin
			halt_q <= 1'b0;
		end
	end

	// region stays blocked until software re-enables it
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rww_busy_q <= 1'b0;
		end else if (start_op && in_rww(ptr_page)) begin
			rww_busy_q <= 1'b1;
		end else if (store_hit && action_q == PAT_REENABLE && op_q == OP_IDLE) begin
			rww_busy_q <= 1'b0;
		end
	end

	assign o_core_halt          = halt_q;
	assign o_rww_read_blocked   = rww_busy_q;
	assign o_flash_read_blocked = halt_q;
	assign o_array_start        = start_op;
	assign o_array_write        = (op_q == OP_WRITE);
	assign o_array_page         = op_if.page_latched;

	// ------------------------------------------------------------
	// temporary page buffer
	// ------------------------------------------------------------
	logic       buf_store;
	logic [5:0] buf_idx;
	assign buf_store = store_hit && action_q == PAT_STORE && !sig_q;
	assign buf_idx   = i_pointer[PAGE_WORD_W:1];

	always_ff @(posedge i_core_clk) begin
		if (buf_store) begin
			buf_mem[buf_idx] <= i_operand_pair;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			buf_valid_q   <= '0;
			buf_filling_q <= 1'b0;
		end else if (store_hit && action_q == PAT_REENABLE && buf_filling_q) begin
			buf_valid_q   <= '0;
			buf_filling_q <= 1'b0;
		end else if (buf_store) begin
			buf_valid_q[buf_idx] <= 1'b1;
			buf_filling_q        <= 1'b1;
		end else if (op_if.done && op_q == OP_WRITE) begin
			buf_valid_q   <= '0;
			buf_filling_q <= 1'b0;
		end
	end

	// array reads one buffer word at a time; unwritten words read erased
	assign o_buf_index = o_array_page[PAGE_WORD_W-1:0];
	assign o_buf_word  = buf_valid_q[o_buf_index] ? buf_mem[o_buf_index] : 16'hffff;

	// ------------------------------------------------------------
	// loads: lock, fuse, signature
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			load_data_q <= 8'h00;
			load_ovr_q  <= 1'b0;
		end else begin
			load_ovr_q <= load_hit && (action_q == PAT_LOCKFUSE || sig_q);
			if (load_hit && sig_q) begin
				load_data_q <= i_signature_byte;
			end else if (load_hit && action_q == PAT_LOCKFUSE) begin
				case (i_pointer[1:0])
					SEL_LOCK:      load_data_q <= i_lock_bits;
					SEL_FUSE_LOW:  load_data_q <= i_fuse_low;
					SEL_FUSE_HIGH: load_data_q <= i_fuse_high;
					SEL_FUSE_EXT:  load_data_q <= i_fuse_ext;
					default:       load_data_q <= 8'h00;
				endcase
			end
		end
	end
	assign o_load_data     = load_data_q;
	assign o_load_override = load_ovr_q;

	// ------------------------------------------------------------
	// interrupt request and read port
	// ------------------------------------------------------------
	assign o_store_ready_irq = irq_en_q && i_global_irq_en && !action_q[BIT_STORE_EN] &&
		!i_eeprom_busy && (op_q == OP_IDLE);

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= 8'h00;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_CONTROL: rdata_q <= {irq_en_q, rww_busy_q && HAS_RWW, 1'b0, action_q};
				ADDR_RDATA:   rdata_q <= load_data_q;
				default:      rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign o_reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	irq_suppress_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_eeprom_busy || op_q != OP_IDLE) |-> !o_store_ready_irq) else $error("irq during store");
	irq_request_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(irq_en_q && i_global_irq_en && !action_q[0] && !i_eeprom_busy && op_q == OP_IDLE)
		|-> o_store_ready_irq) else $error("irq missing");
	arm_timeout_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ctl_wr && pattern_ok && !action_q[0] && op_q == OP_IDLE && !op_if.done)
		##1 (!i_store_instr && !i_load_instr) [*4] |=> action_q == 5'h00)
		else $error("arm not timed out");
	bad_pattern_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(ctl_wr && !pattern_ok && action_q == 5'h00 && op_q == OP_IDLE) |=> action_q == 5'h00)
		else $error("illegal pattern armed");
	app_store_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		!in_loader(i_fetch_addr) |-> !o_array_start) else $error("store from application");
	halt_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(start_op && !in_rww(ptr_page)) |=> (o_core_halt && action_q[0]) until op_if.done)
		else $error("halt dropped");
	rww_run_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(start_op && in_rww(ptr_page)) |=> !o_core_halt && o_rww_read_blocked)
		else $error("rww halted");
	sig_store_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(sig_q && action_q[0]) |-> !o_array_start && !buf_store) else $error("signature store acted");
	fuse_sel_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		(load_hit && action_q == PAT_LOCKFUSE && i_pointer[1:0] == SEL_LOCK) |=> load_data_q == $past(i_lock_bits))
		else $error("lock read wrong");
endmodule

// ===== pkg/flash_spc_pkg.sv
// shared constants and types for the flash self-program control block
package flash_spc_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_CONTROL    = 4'h0;
	localparam logic [3:0] ADDR_RDATA      = 4'h1;
	localparam logic [7:0] CONTROL_RESET   = 8'h00;
	// control bit positions
	localparam int BIT_IRQ_EN   = 7;
	localparam int BIT_BUSY     = 6;
	localparam int BIT_SIG      = 5;
	localparam int BIT_REENABLE = 4;
	localparam int BIT_LOCKFUSE = 3;
	localparam int BIT_PGWRITE  = 2;
	localparam int BIT_PGERASE  = 1;
	localparam int BIT_STORE_EN = 0;
	// signature select sits above the five action bits, beside a bare store enable
	localparam logic [5:0] PAT_SIG      = 6'h21;
	// legal low-five-bit patterns
	localparam logic [4:0] PAT_REENABLE = 5'h11;
	localparam logic [4:0] PAT_LOCKFUSE = 5'h09;
	localparam logic [4:0] PAT_PGWRITE  = 5'h05;
	localparam logic [4:0] PAT_PGERASE  = 5'h03;
	localparam logic [4:0] PAT_STORE    = 5'h01;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam logic [2:0] STORE_WINDOW = 3'h4;
	localparam logic [2:0] LOAD_WINDOW  = 3'h3;
	// lock/fuse pointer selects
	localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
	localparam logic [1:0] SEL_LOCK      = 2'h1;
	localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
	localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;
	// flash geometry
	localparam int ADDR_W      = 15;
	localparam int PAGE_WORD_W = 6;
	localparam int PAGE_W      = ADDR_W - PAGE_WORD_W;
	localparam int BUF_WORDS   = 64;
	typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} op_type;
endpackage

// ===== pkg/flash_op_if.sv
// handshake between the sequencer and its array-operation tracker
`timescale 1ns/10ps
interface flash_op_if;
	import flash_spc_pkg::*;
	logic                start;
	logic                is_write;
	logic [PAGE_W-1:0]   page;
	logic                rww_target;
	logic                busy;
	logic                done;
	logic [PAGE_W-1:0]   page_latched;
	modport seq (output start, is_write, page, rww_target, input busy, done, page_latched);
	modport trk (input start, is_write, page, rww_target, output busy, done, page_latched);
endinterface

// ===== rtl/flash_op_tracker.sv
// tracks one page erase or write and latches its page address
`timescale 1ns/10ps
module flash_op_tracker (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst_n,
	// array side
	input  wire logic i_array_done,
	// sequencer
	flash_op_if.trk   op
);
	import flash_spc_pkg::*;
	logic              busy_q;
	logic              done_q;
	logic [PAGE_W-1:0] page_q;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q <= 1'b0;
		end else if (op.start) begin
			busy_q <= 1'b1;
		end else if (i_array_done) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			done_q <= 1'b0;
		end else begin
			done_q <= busy_q & i_array_done & ~op.start;
		end
	end

	// later pointer changes must not move a running operation
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			page_q <= '0;
		end else if (op.start) begin
			page_q <= op.page;
		end
	end

	assign op.busy         = busy_q;
	assign op.done         = done_q;
	assign op.page_latched = page_q;

	page_latch_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
		op.start |=> page_q == $past(op.page)) else $error("page not latched");
endmodule

// ===== test/core_model.sv
// processor core and flash array stand-in facing the self-program control block
`timescale 1ns/10ps
module core_model (
	// clock
	input  wire logic                         i_core_clk,
	// from the block
	input  wire logic                         i_array_start,
	// core instruction side and array completion
	output logic                              o_store_instr,
	output logic                              o_load_instr,
	output logic [15:0]                       o_pointer,
	output logic [15:0]                       o_operand_pair,
	output logic [flash_spc_pkg::ADDR_W-1:0]  o_fetch_addr,
	output logic                              o_array_done
);
	import flash_spc_pkg::*;
	int done_dly = 4;
	int starts = 0;
	int wait_q = 0;
	initial begin
		o_store_instr = 1'b0;
		o_load_instr = 1'b0;
		o_pointer = 16'h0000;
		o_operand_pair = 16'h0000;
		o_fetch_addr = 15'h7000;
		o_array_done = 1'b0;
	end
	// ------------------------------------------------------------
	// array: done pulse a set number of cycles after each start
	// ------------------------------------------------------------
	always @(posedge i_core_clk) begin
		o_array_done <= 1'b0;
		o_store_instr <= 1'b0;
		o_load_instr <= 1'b0;
		if (i_array_start === 1'b1) begin
			starts++;
			wait_q = done_dly;
		end else if (wait_q > 0) begin
			wait_q--;
			if (wait_q == 0)
				o_array_done <= 1'b1;
		end
	end
	// ------------------------------------------------------------
	// one store or load instruction
	// ------------------------------------------------------------
	task automatic instr(input bit st, input logic [15:0] p, input logic [15:0] d, input logic [ADDR_W-1:0] pc);
		o_pointer <= p;
		o_operand_pair <= d;
		o_fetch_addr <= pc;
		o_store_instr <= st;
		o_load_instr <= !st;
		@(posedge i_core_clk);
		#1;
		// the core moves on, so the pointer does not hold for the block
		o_pointer <= ~p;
		o_operand_pair <= ~d;
	endtask
endmodule

// ===== test/test_flash_self_program_control.sv
// self-checking bench for the flash self-program control block
`timescale 1ns/10ps
module test_flash_self_program_control;
	import flash_spc_pkg::*;
	localparam logic [ADDR_W-1:0] LDR = 15'h7000;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	logic                   clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic [3:0]             addr = 4'h0;
	logic [7:0]             wdata = 8'h00;
	logic                   wr = 1'b0;
	logic                   rd = 1'b0;
	logic                   gie = 1'b0;
	logic                   ee_busy = 1'b0;
	logic [7:0]             fb [4] = '{8'h3c, 8'h5a, 8'h96, 8'hc3};
	logic [7:0]             sig = 8'he7;
	logic [7:0]             rdata, ld_data, v;
	logic                   ld_ovr, halt, rww_blk, fl_blk, irq, a_start, a_write, st, ld, a_done;
	logic [PAGE_W-1:0]      a_page;
	logic [15:0]            b_word, ptr, opd;
	logic [PAGE_WORD_W-1:0] b_idx;
	logic [ADDR_W-1:0]      pc;
	int                     fails = 0;
	int                     n_checks = 0;
	int                     cyc = 0;
	flash_self_program_control i_flash_self_program_control (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .i_store_instr(st), .i_load_instr(ld), .i_pointer(ptr),
		.i_operand_pair(opd), .i_fetch_addr(pc), .i_global_irq_en(gie), .i_eeprom_busy(ee_busy),
		.o_load_data(ld_data), .o_load_override(ld_ovr), .o_core_halt(halt), .o_rww_read_blocked(rww_blk),
		.o_flash_read_blocked(fl_blk), .o_store_ready_irq(irq), .i_lock_bits(fb[1]), .i_fuse_low(fb[0]),
		.i_fuse_high(fb[3]), .i_fuse_ext(fb[2]), .i_signature_byte(sig), .i_array_done(a_done),
		.o_array_start(a_start), .o_array_write(a_write), .o_array_page(a_page), .o_buf_word(b_word),
		.o_buf_index(b_idx)
	);
	core_model i_core_model (
		.i_core_clk(clk), .i_array_start(a_start), .o_store_instr(st), .o_load_instr(ld),
		.o_pointer(ptr), .o_operand_pair(opd), .o_fetch_addr(pc), .o_array_done(a_done)
	);
	always #10 clk = ~clk;
	// strobes last one cycle: cleared here, raised by tasks 1 ns after the edge
	always @(posedge clk) begin
		wr <= 1'b0;
		rd <= 1'b0;
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] s, input logic [7:0] e);
		check({8'h00, s}, {8'h00, e});
	endtask
	task automatic chk1(input logic s, input logic e);
		check({15'h0000, s}, {15'h0000, e});
	endtask
	task automatic reg_wr(input logic [7:0] d);
		addr <= ADDR_CONTROL;
		wdata <= d;
		wr <= 1'b1;
		step();
	endtask
	task automatic reg_rd(input logic [3:0] a);
		addr <= a;
		rd <= 1'b1;
		step();
		v = rdata;
	endtask
	function automatic logic [7:0] act(input int b);
		return 8'(1 << b) | 8'h01;
	endfunction
	task automatic store(input logic [15:0] p, input logic [15:0] d, input logic [ADDR_W-1:0] a);
		i_core_model.instr(1'b1, p, d, a);
	endtask
	task automatic wait_halt();
		for (int k = 0; k < 60 && halt !== 1'b0; k++)
			step();
		chk1(halt, 1'b0);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		reg_rd(ADDR_CONTROL);
		chk8(v, 8'h00);
		reg_rd(4'h7);
		chk8(v, 8'h00);
		chk1(halt, 1'b0);
	endtask
	task automatic t_irq();
		gie <= 1'b1;
		reg_wr(8'h80);
		chk1(irq, 1'b1);
		ee_busy <= 1'b1;
		step();
		chk1(irq, 1'b0);
		ee_busy <= 1'b0;
		reg_wr(8'h81);
		chk1(irq, 1'b0);
		repeat (4) step();
		reg_rd(ADDR_CONTROL);
		chk8(v, 8'h80);
		chk1(irq, 1'b1);
		gie <= 1'b0;
		reg_wr(8'h00);
		chk1(irq, 1'b0);
	endtask
	task automatic t_lockfuse();
		for (int p = 0; p < 4; p++) begin
			reg_wr(act(BIT_LOCKFUSE));
			// odd pointers load on the last cycle of the window
			repeat (p % 2 * 2) step();
			i_core_model.instr(1'b0, 16'(p), 16'h0000, LDR);
			chk8(ld_data, fb[p]);
			chk1(ld_ovr, 1'b1);
			reg_rd(ADDR_CONTROL);
			chk8(v, 8'h00);
		end
		reg_wr(act(BIT_LOCKFUSE));
		repeat (3) step();
		i_core_model.instr(1'b0, 16'h0001, 16'h0000, LDR);
		chk1(ld_ovr, 1'b0);
	endtask
	task automatic t_sig();
		int n;
		reg_wr(act(BIT_SIG));
		i_core_model.instr(1'b0, 16'h0000, 16'h0000, LDR);
		chk8(ld_data, sig);
		repeat (4) step();
		n = i_core_model.starts;
		reg_wr(act(BIT_SIG));
		store(16'he180, 16'h0000, LDR);
		step();
		chk1(i_core_model.starts == n, 1'b1);
		chk1(halt, 1'b0);
		repeat (4) step();
	endtask
	task automatic t_refuse();
		logic [7:0] pats [6] = '{act(BIT_PGWRITE), act(BIT_PGERASE), 8'h01, 8'h07, 8'h1f, 8'h02};
		int n;
		n = i_core_model.starts;
		foreach (pats[i]) begin
			reg_wr(pats[i]);
			reg_rd(ADDR_CONTROL);
			chk8(v, (i < 3) ? pats[i] : 8'h00);
			repeat (3) step();
			reg_rd(ADDR_CONTROL);
			chk8(v, 8'h00);
			store(16'he180, 16'h0000, LDR);
		end
		step();
		chk1(i_core_model.starts == n, 1'b1);
		reg_wr(act(BIT_PGERASE));
		store(16'he180, 16'h0000, 15'h0100);
		step();
		chk1(halt, 1'b0);
		chk1(i_core_model.starts == n, 1'b1);
		repeat (5) step();
	endtask
	task automatic t_hwrite();
		i_core_model.done_dly = 30;
		reg_wr(8'h01);
		store(16'h0086, 16'hbeef, LDR);
		reg_rd(ADDR_CONTROL);
		chk8(v, 8'h00);
		reg_wr(act(BIT_PGWRITE));
		store(16'he180, 16'h0000, LDR);
		step();
		chk1(halt, 1'b1);
		chk1(fl_blk, 1'b1);
		chk1(a_write, 1'b1);
		check(16'(a_page), 16'h01c3);
		check(16'(b_idx), 16'h0003);
		check(b_word, 16'hbeef);
		reg_rd(ADDR_CONTROL);
		chk8(v, act(BIT_PGWRITE));
		wait_halt();
		reg_rd(ADDR_CONTROL);
		chk8(v, 8'h00);
	endtask
	task automatic t_rww();
		i_core_model.done_dly = 2;
		reg_wr(act(BIT_PGERASE));
		repeat (3) step();
		store(16'h0280, 16'h0000, LDR);
		step();
		chk1(halt, 1'b0);
		chk1(fl_blk, 1'b0);
		chk1(rww_blk, 1'b1);
		chk1(a_write, 1'b0);
		check(16'(a_page), 16'h0005);
		reg_rd(ADDR_CONTROL);
		for (int k = 0; k < 40 && v[BIT_STORE_EN] !== 1'b0; k++)
			reg_rd(ADDR_CONTROL);
		chk8(v, 8'h40);
		reg_wr(8'h01);
		store(16'h000a, 16'h1234, LDR);
		step();
		// busy flag cleared before any read of the region
		reg_wr(act(BIT_REENABLE));
		store(16'h0000, 16'h0000, LDR);
		reg_rd(ADDR_CONTROL);
		chk8(v, 8'h00);
		chk1(rww_blk, 1'b0);
		reg_wr(act(BIT_PGWRITE));
		store(16'he280, 16'h0000, LDR);
		step();
		check(b_word, 16'hffff);
		wait_halt();
	endtask
	// ------------------------------------------------------------
	// run
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		step();
		t_reset();
		t_irq();
		t_lockfuse();
		t_sig();
		t_refuse();
		t_hwrite();
		t_rww();
		end_of_test();
	end
endmodule
